//--- core/msc_config_bank.sv
// Configuration register bank with escape detection and RS485 enable lead
// Function
// - RF output level accepts codes 0..3, default 3 (27 dBm)
// - Baud code 1..7 maps 1200..57600, default 4 (9600)
// - Data length 7/8, parity 1..3, stop bits 1..2, defaults 8/none/1
// - Escape guard timeout in 10 ms units, 1..100, default 8
// - Line type 0 is RS232; 1 gives RS485 when strap grounded
// - Flow control 0 enables RTS handshake, 2 disables it, default 2
// - RS485 driver enable leads first byte by programmed delay 0..160
// - Hopping band 2 whole, 3 low, 4 high, default 2
// - Addressed mode drops frames whose address differs from receive address
// - Addressed mode tags outgoing frames with transmit address
// - PIN code defaults to 1111 and refuses 0000
// - PIN lock enable 1 turns command protection on, default off
// - Power management enable gates the sleep request input
// - Baud change raises guard timeout to three character times
// - Response uses old format; new format applies afterwards
// - Set writes number and value; query answers number and value
// - Registers load from storage at power-up; save command persists them
// - Command mode only on +++ with guard silence both sides
`timescale 1ns/1ps
`include "msc_params.svh"
module msc_config_bank
    import msc_pkg::*;
#(
    parameter int GUARD_UNIT_CYC = `MSC_GUARD_UNIT_CYC
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Decoded command port
    input wire logic cmd_valid_in,
    input msc_cmd_t cmd_in,
    output logic cmd_ready_out,
    output logic rsp_valid_out,
    output msc_rsp_t rsp_out,
    // Non-volatile storage, one cycle read latency
    output logic [3:0] nv_addr_out,
    output logic nv_we_out,
    output logic [15:0] nv_wdata_out,
    input wire logic [15:0] nv_rdata_in,
    // Serial receive characters and escape
    input wire logic rx_char_valid_in,
    input wire logic [7:0] rx_char_in,
    input wire logic cmd_exit_in,
    output logic cmd_mode_out,
    // Line driver
    input wire logic iface_strap_in,
    input wire logic tx_req_in,
    output logic driver_en_out,
    output logic tx_go_out,
    // Frame addressing
    input wire logic addressed_mode_in,
    input wire logic rx_adr_valid_in,
    input wire logic [15:0] rx_adr_in,
    output logic frame_accept_out,
    output logic [15:0] tx_tag_out,
    // Configuration outputs
    output msc_fmt_t fmt_out,
    output logic rs485_out,
    output logic rts_en_out,
    output logic [1:0] rf_level_out,
    output logic [2:0] band_out,
    output logic [1:0] retries_out,
    output logic pin_lock_out,
    output logic [15:0] pin_code_out,
    input wire logic sleep_request_in,
    output logic sleep_out
);
    localparam int NREG = 16;
    localparam int GW = $clog2(GUARD_UNIT_CYC + 1);
    localparam logic [GW-1:0] GUARD_LAST = GW'(GUARD_UNIT_CYC - 1);
    localparam logic [5:0] LEAD_LAST = 6'(`MSC_LEAD_UNIT_CYC - 1);

    function automatic logic [8:0] num_of(input logic [3:0] i);
        case (i)
            4'h0: num_of = `MSC_OFS_PIN;
            4'h1: num_of = `MSC_OFS_LOCK;
            4'h2: num_of = `MSC_OFS_BAUD;
            4'h3: num_of = `MSC_OFS_DLEN;
            4'h4: num_of = `MSC_OFS_PAR;
            4'h5: num_of = `MSC_OFS_STOP;
            4'h6: num_of = `MSC_OFS_GUARD;
            4'h7: num_of = `MSC_OFS_LINE;
            4'h8: num_of = `MSC_OFS_FLOW;
            4'h9: num_of = `MSC_OFS_LEAD;
            4'ha: num_of = `MSC_OFS_BAND;
            4'hb: num_of = `MSC_OFS_RETRY;
            4'hc: num_of = `MSC_OFS_RF;
            4'hd: num_of = `MSC_OFS_PM;
            4'he: num_of = `MSC_OFS_RXADR;
            default: num_of = `MSC_OFS_TXADR;
        endcase
    endfunction : num_of

    function automatic logic [3:0] idx_of(input logic [8:0] n);
        idx_of = 4'h0;
        for (int i = 0; i < NREG; i++) begin
            if (num_of(4'(i)) == n) begin
                idx_of = 4'(i);
            end
        end
    endfunction : idx_of

    function automatic logic mapped(input logic [8:0] n);
        mapped = (num_of(idx_of(n)) == n);
    endfunction : mapped

    function automatic logic [15:0] dflt(input logic [8:0] n);
        case (n)
            `MSC_OFS_PIN: dflt = `MSC_RST_PIN;
            `MSC_OFS_LOCK: dflt = `MSC_RST_LOCK;
            `MSC_OFS_BAUD: dflt = `MSC_RST_BAUD;
            `MSC_OFS_DLEN: dflt = `MSC_RST_DLEN;
            `MSC_OFS_PAR: dflt = `MSC_RST_PAR;
            `MSC_OFS_STOP: dflt = `MSC_RST_STOP;
            `MSC_OFS_GUARD: dflt = `MSC_RST_GUARD;
            `MSC_OFS_LINE: dflt = `MSC_RST_LINE;
            `MSC_OFS_FLOW: dflt = `MSC_RST_FLOW;
            `MSC_OFS_LEAD: dflt = `MSC_RST_LEAD;
            `MSC_OFS_BAND: dflt = `MSC_RST_BAND;
            `MSC_OFS_RETRY: dflt = `MSC_RST_RETRY;
            `MSC_OFS_RF: dflt = `MSC_RST_RF;
            `MSC_OFS_PM: dflt = `MSC_RST_PM;
            `MSC_OFS_RXADR: dflt = `MSC_RST_RXADR;
            default: dflt = `MSC_RST_TXADR;
        endcase
    endfunction : dflt

    // Legal code set per register
    function automatic logic legal(input logic [8:0] n, input logic [15:0] v);
        case (n)
            `MSC_OFS_PIN: legal = (v != 16'h0000);
            `MSC_OFS_LOCK, `MSC_OFS_PM, `MSC_OFS_LINE: legal = (v <= 16'h0001);
            `MSC_OFS_BAUD: legal = (v >= 16'h0001) && (v <= 16'h0007);
            `MSC_OFS_DLEN: legal = (v == 16'h0007) || (v == 16'h0008);
            `MSC_OFS_PAR: legal = (v >= 16'h0001) && (v <= 16'h0003);
            `MSC_OFS_STOP: legal = (v >= 16'h0001) && (v <= 16'h0002);
            `MSC_OFS_GUARD: legal = (v >= 16'h0001) && (v <= `MSC_GUARD_MAX);
            `MSC_OFS_FLOW: legal = (v == 16'h0000) || (v == 16'h0002);
            `MSC_OFS_LEAD: legal = (v <= `MSC_LEAD_MAX);
            `MSC_OFS_BAND: legal = (v >= 16'h0002) && (v <= 16'h0004);
            `MSC_OFS_RETRY: legal = (v <= 16'h0002);
            `MSC_OFS_RF: legal = (v <= 16'h0003);
            default: legal = 1'b1;
        endcase
    endfunction : legal

    // Guard units covering three 11-bit characters at a baud code
    function automatic logic [15:0] min_guard(input logic [15:0] baud);
        case (baud)
            16'h0001: min_guard = 16'h0003;
            16'h0002: min_guard = 16'h0002;
            default: min_guard = 16'h0001;
        endcase
    endfunction : min_guard

    logic [15:0] regs_r [NREG];
    logic [15:0] regs_nxt [NREG];
    msc_state_t state_r, state_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic ld_wr_r, ld_wr_nxt;
    logic strap_r, strap_nxt;
    logic rsp_valid_r, rsp_valid_nxt;
    msc_rsp_t rsp_r, rsp_nxt;
    msc_fmt_t fmt_r, fmt_nxt;
    logic [3:0] ci;

    wire logic [15:0] guard_v = regs_r[idx_of(`MSC_OFS_GUARD)];
    wire logic [15:0] baud_v = regs_r[idx_of(`MSC_OFS_BAUD)];
    wire logic [15:0] lead_v = regs_r[idx_of(`MSC_OFS_LEAD)];

    always_comb begin
        for (int i = 0; i < NREG; i++) begin
            regs_nxt[i] = regs_r[i];
        end
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        ld_wr_nxt = 1'b0;
        strap_nxt = strap_r;
        rsp_valid_nxt = 1'b0;
        rsp_nxt = rsp_r;
        fmt_nxt = fmt_r;
        ci = idx_of(cmd_in.num);
        if (rsp_valid_r || state_r == MSC_ST_LOAD) begin
            fmt_nxt.baud_code = baud_v[2:0];
            fmt_nxt.bits8 = (regs_r[idx_of(`MSC_OFS_DLEN)] == 16'h0008);
            fmt_nxt.parity_code = regs_r[idx_of(`MSC_OFS_PAR)][1:0];
            fmt_nxt.stop2 = (regs_r[idx_of(`MSC_OFS_STOP)] == 16'h0002);
        end
        case (state_r)
            // Power-up load, bad entries fall back to default
            MSC_ST_LOAD: begin
                ld_wr_nxt = 1'b1;
                cnt_nxt = cnt_r + 4'h1;
                if (ld_wr_r) begin
                    regs_nxt[cnt_r - 4'h1] = legal(num_of(cnt_r - 4'h1), nv_rdata_in) ?
                        nv_rdata_in : dflt(num_of(cnt_r - 4'h1));
                end
                if (ld_wr_r && cnt_r == 4'h0) begin
                    state_nxt = MSC_ST_IDLE;
                    ld_wr_nxt = 1'b0;
                    strap_nxt = iface_strap_in;
                end
            end
            MSC_ST_IDLE: begin
                if (cmd_valid_in) begin
                    rsp_nxt.num = cmd_in.num;
                    rsp_nxt.value = regs_r[ci];
                    rsp_nxt.ok = mapped(cmd_in.num);
                    rsp_valid_nxt = 1'b1;
                    case (cmd_in.op)
                        MSC_OP_SET: begin
                            rsp_nxt.ok = mapped(cmd_in.num) && legal(cmd_in.num, cmd_in.value);
                            if (rsp_nxt.ok) begin
                                regs_nxt[ci] = cmd_in.value;
                                rsp_nxt.value = cmd_in.value;
                                if (cmd_in.num == `MSC_OFS_BAUD &&
                                    guard_v < min_guard(cmd_in.value)) begin
                                    regs_nxt[idx_of(`MSC_OFS_GUARD)] = min_guard(cmd_in.value);
                                end
                            end
                        end
                        MSC_OP_QUERY: begin
                        end
                        MSC_OP_SAVE: begin
                            rsp_valid_nxt = 1'b0;
                            state_nxt = MSC_ST_SAVE;
                            cnt_nxt = 4'h0;
                        end
                        default: begin
                            for (int i = 0; i < NREG; i++) begin
                                regs_nxt[i] = dflt(num_of(4'(i)));
                            end
                            rsp_nxt.ok = 1'b1;
                        end
                    endcase
                end
            end
            MSC_ST_SAVE: begin
                cnt_nxt = cnt_r + 4'h1;
                if (cnt_r == 4'hf) begin
                    state_nxt = MSC_ST_IDLE;
                    rsp_valid_nxt = 1'b1;
                    rsp_nxt.ok = 1'b1;
                end
            end
            default: state_nxt = MSC_ST_LOAD;
        endcase
    end

    for (genvar g = 0; g < NREG; g++) begin : g_reg
        always_ff @(posedge clk_in or posedge reset_in) begin
            if (reset_in) begin
                regs_r[g] <= dflt(num_of(4'(g)));
            end else begin
                regs_r[g] <= regs_nxt[g];
            end
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_r <= MSC_ST_LOAD;
            cnt_r <= 4'h0;
            ld_wr_r <= 1'b0;
            strap_r <= 1'b1;
            rsp_valid_r <= 1'b0;
            rsp_r <= '0;
            fmt_r <= '0;
            cmd_ready_out <= 1'b0;
            nv_addr_out <= 4'h0;
            nv_we_out <= 1'b0;
            nv_wdata_out <= 16'h0000;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            ld_wr_r <= ld_wr_nxt;
            strap_r <= strap_nxt;
            rsp_valid_r <= rsp_valid_nxt;
            rsp_r <= rsp_nxt;
            fmt_r <= fmt_nxt;
            cmd_ready_out <= (state_nxt == MSC_ST_IDLE) && !rsp_valid_nxt;
            nv_addr_out <= cnt_nxt;
            nv_we_out <= (state_nxt == MSC_ST_SAVE);
            nv_wdata_out <= regs_nxt[cnt_nxt];
        end
    end

    // Escape detector and line driver state
    logic [GW-1:0] tick_cnt_r, tick_cnt_nxt;
    logic [6:0] sil_r, sil_nxt;
    logic [1:0] plus_r, plus_nxt;
    logic cmd_mode_r, cmd_mode_nxt;
    logic [5:0] lead_div_r, lead_div_nxt;
    logic [7:0] lead_cnt_r, lead_cnt_nxt;
    logic de_r, de_nxt;
    logic go_r, go_nxt;
    logic sent_r, sent_nxt;
    logic quiet;
    logic rs485;

    always_comb begin
        tick_cnt_nxt = (tick_cnt_r == GUARD_LAST) ? '0 : tick_cnt_r + GW'(1);
        sil_nxt = sil_r;
        if (tick_cnt_r == GUARD_LAST && sil_r != 7'h7f) begin
            sil_nxt = sil_r + 7'h01;
        end
        plus_nxt = plus_r;
        cmd_mode_nxt = cmd_mode_r && !cmd_exit_in;
        quiet = ({9'h000, sil_r} >= guard_v);
        // Guard counted in 10 ms ticks
        if (rx_char_valid_in) begin
            tick_cnt_nxt = '0;
            sil_nxt = 7'h00;
            if (rx_char_in == `MSC_ESC_CHAR && plus_r != 2'h3 &&
                (plus_r != 2'h0 || quiet)) begin
                plus_nxt = plus_r + 2'h1;
            end else begin
                plus_nxt = 2'h0;
            end
        end else if (plus_r == 2'h3 && quiet) begin
            plus_nxt = 2'h0;
            cmd_mode_nxt = 1'b1;
        end
        // Line selection from type and strap
        rs485 = (regs_r[idx_of(`MSC_OFS_LINE)] == 16'h0001) && !strap_r;
        lead_div_nxt = (lead_div_r == LEAD_LAST) ? 6'h00 : lead_div_r + 6'h01;
        lead_cnt_nxt = lead_cnt_r;
        de_nxt = tx_req_in && rs485;
        go_nxt = 1'b0;
        sent_nxt = sent_r && tx_req_in;
        // Driver enable leads the first byte
        if (!de_r) begin
            lead_div_nxt = 6'h00;
            lead_cnt_nxt = 8'h00;
        end else if (lead_div_r == LEAD_LAST && lead_cnt_r != 8'hff) begin
            lead_cnt_nxt = lead_cnt_r + 8'h01;
        end
        if (tx_req_in && !sent_r && (!rs485 || (de_r && {8'h00, lead_cnt_r} >= lead_v))) begin
            go_nxt = 1'b1;
            sent_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            tick_cnt_r <= '0;
            sil_r <= 7'h00;
            plus_r <= 2'h0;
            cmd_mode_r <= 1'b0;
            lead_div_r <= 6'h00;
            lead_cnt_r <= 8'h00;
            de_r <= 1'b0;
            go_r <= 1'b0;
            sent_r <= 1'b0;
            frame_accept_out <= 1'b0;
            sleep_out <= 1'b0;
            rs485_out <= 1'b0;
            rts_en_out <= 1'b0;
        end else begin
            tick_cnt_r <= tick_cnt_nxt;
            sil_r <= sil_nxt;
            plus_r <= plus_nxt;
            cmd_mode_r <= cmd_mode_nxt;
            lead_div_r <= lead_div_nxt;
            lead_cnt_r <= lead_cnt_nxt;
            de_r <= de_nxt;
            go_r <= go_nxt;
            sent_r <= sent_nxt;
            frame_accept_out <= rx_adr_valid_in &&
                (!addressed_mode_in || rx_adr_in == regs_r[idx_of(`MSC_OFS_RXADR)]);
            sleep_out <= sleep_request_in && regs_r[idx_of(`MSC_OFS_PM)][0];
            rs485_out <= rs485;
            rts_en_out <= (regs_r[idx_of(`MSC_OFS_FLOW)] == 16'h0000);
        end
    end

    // Register-backed outputs; codes pass straight out
    assign rsp_valid_out = rsp_valid_r;
    assign rsp_out = rsp_r;
    assign fmt_out = fmt_r;
    assign cmd_mode_out = cmd_mode_r;
    assign driver_en_out = de_r;
    assign tx_go_out = go_r;
    assign tx_tag_out = regs_r[idx_of(`MSC_OFS_TXADR)];
    assign rf_level_out = regs_r[idx_of(`MSC_OFS_RF)][1:0];
    assign band_out = regs_r[idx_of(`MSC_OFS_BAND)][2:0];
    assign retries_out = regs_r[idx_of(`MSC_OFS_RETRY)][1:0];
    assign pin_lock_out = regs_r[idx_of(`MSC_OFS_LOCK)][0];
    assign pin_code_out = regs_r[idx_of(`MSC_OFS_PIN)];

    chk_pin_nonzero: assert property (@(posedge clk_in) disable iff (reset_in)
        pin_code_out != 16'h0000) else $error("pin code became zero");
    chk_rf_range: assert property (@(posedge clk_in) disable iff (reset_in)
        regs_r[idx_of(`MSC_OFS_RF)] <= 16'h0003) else $error("rf level out of range");
    chk_reject_keeps: assert property (@(posedge clk_in) disable iff (reset_in)
        (state_r == MSC_ST_IDLE && cmd_valid_in && cmd_in.op == MSC_OP_SET &&
         mapped(cmd_in.num) && !legal(cmd_in.num, cmd_in.value))
        |=> !rsp_out.ok && regs_r[idx_of(rsp_out.num)] == $past(regs_r[idx_of(cmd_in.num)]))
        else $error("illegal write changed a register");
    chk_fmt_after_rsp: assert property (@(posedge clk_in) disable iff (reset_in)
        rsp_valid_out |-> $stable(fmt_out) ##1 fmt_out.baud_code == $past(baud_v[2:0]))
        else $error("format not applied after response");
    chk_guard_raise: assert property (@(posedge clk_in) disable iff (reset_in)
        ($past(cmd_valid_in && cmd_in.op == MSC_OP_SET) && rsp_valid_out && rsp_out.ok &&
         rsp_out.num == `MSC_OFS_BAUD)
        |-> guard_v >= min_guard(baud_v)) else $error("guard below three characters");
    chk_rts_map: assert property (@(posedge clk_in) disable iff (reset_in)
        $stable(regs_r[idx_of(`MSC_OFS_FLOW)])
        |=> rts_en_out == ($past(regs_r[idx_of(`MSC_OFS_FLOW)]) == 16'h0000))
        else $error("rts enable mismatch");
    chk_lead_delay: assert property (@(posedge clk_in) disable iff (reset_in)
        (tx_go_out && rs485_out) |-> driver_en_out && {8'h00, $past(lead_cnt_r)} >= lead_v)
        else $error("byte sent before lead delay");
    chk_sleep_gate: assert property (@(posedge clk_in) disable iff (reset_in)
        sleep_out |-> $past(sleep_request_in) && $past(regs_r[idx_of(`MSC_OFS_PM)][0]))
        else $error("sleep without enable");
    chk_escape_quiet: assert property (@(posedge clk_in) disable iff (reset_in)
        $rose(cmd_mode_out) |-> $past(plus_r) == 2'h3 && !$past(rx_char_valid_in))
        else $error("command mode without escape");
endmodule : msc_config_bank

//--- core/msc_params.svh
// Register numbers, reset values and timing counts of the modem serial config bank
`ifndef MSC_PARAMS_SVH
`define MSC_PARAMS_SVH
`define MSC_OFS_PIN 9'h0cd
`define MSC_OFS_LOCK 9'h0cf
`define MSC_OFS_BAUD 9'h0d2
`define MSC_OFS_DLEN 9'h0d3
`define MSC_OFS_PAR 9'h0d4
`define MSC_OFS_STOP 9'h0d5
`define MSC_OFS_GUARD 9'h0d6
`define MSC_OFS_LINE 9'h0d7
`define MSC_OFS_FLOW 9'h0d8
`define MSC_OFS_LEAD 9'h0db
`define MSC_OFS_BAND 9'h0dc
`define MSC_OFS_RETRY 9'h0dd
`define MSC_OFS_RF 9'h0e7
`define MSC_OFS_PM 9'h0e8
`define MSC_OFS_RXADR 9'h0fc
`define MSC_OFS_TXADR 9'h100
`define MSC_RST_PIN 16'h1111
`define MSC_RST_LOCK 16'h0000
`define MSC_RST_BAUD 16'h0004
`define MSC_RST_DLEN 16'h0008
`define MSC_RST_PAR 16'h0001
`define MSC_RST_STOP 16'h0001
`define MSC_RST_GUARD 16'h0008
`define MSC_RST_LINE 16'h0001
`define MSC_RST_FLOW 16'h0002
`define MSC_RST_LEAD 16'h0003
`define MSC_RST_BAND 16'h0002
`define MSC_RST_RETRY 16'h0000
`define MSC_RST_RF 16'h0003
`define MSC_RST_PM 16'h0000
`define MSC_RST_RXADR 16'h0000
`define MSC_RST_TXADR 16'h0000
`define MSC_GUARD_MAX 16'h0064
`define MSC_LEAD_MAX 16'h00a0
`define MSC_ESC_CHAR 8'h2b
`define MSC_CLK_HZ 40000000
`define MSC_CLK_NS 25
`define MSC_GUARD_UNIT_MS 10
`define MSC_GUARD_UNIT_CYC (`MSC_CLK_HZ / 1000 * `MSC_GUARD_UNIT_MS)
`define MSC_LEAD_UNIT_NS 1000
`define MSC_LEAD_UNIT_CYC ((`MSC_LEAD_UNIT_NS + `MSC_CLK_NS - 1) / `MSC_CLK_NS)
`endif

//--- core/msc_pkg.sv
// Types shared by the modem serial config bank
package msc_pkg;
    typedef enum logic [1:0] {
        MSC_OP_SET = 2'h0,
        MSC_OP_QUERY = 2'h1,
        MSC_OP_SAVE = 2'h2,
        MSC_OP_RESTORE = 2'h3
    } msc_op_t;
    typedef enum logic [1:0] {
        MSC_ST_LOAD = 2'h0,
        MSC_ST_IDLE = 2'h1,
        MSC_ST_SAVE = 2'h3
    } msc_state_t;
    typedef struct packed {
        msc_op_t op;
        logic [8:0] num;
        logic [15:0] value;
    } msc_cmd_t;
    typedef struct packed {
        logic ok;
        logic [8:0] num;
        logic [15:0] value;
    } msc_rsp_t;
    typedef struct packed {
        logic [2:0] baud_code;
        logic bits8;
        logic [1:0] parity_code;
        logic stop2;
    } msc_fmt_t;
endpackage : msc_pkg

//--- sim/msc_nv_model.sv
// Storage model behind the bank, one cycle read latency
`timescale 1ns/1ps
module msc_nv_model (
    // Storage port
    input wire logic clk_in,
    input wire logic [3:0] addr_in,
    input wire logic we_in,
    input wire logic [15:0] wdata_in,
    output logic [15:0] rdata_out
);
    logic [15:0] mem [16] = '{default: 16'hffff};
    always @(posedge clk_in) begin
        if (we_in) mem[addr_in] <= wdata_in;
        rdata_out <= mem[addr_in];
    end
endmodule : msc_nv_model

//--- sim/testbench.sv
// Self-checking bench for the config bank
`timescale 1ns/1ps
module testbench
    import msc_pkg::*;
;
    logic clk_in, reset_in, cmd_valid_in, cmd_ready_out, rsp_valid_out, nv_we_out, sleep_out;
    logic rx_char_valid_in, cmd_exit_in, cmd_mode_out, iface_strap_in, tx_req_in, tx_go_out;
    logic driver_en_out, addressed_mode_in, rx_adr_valid_in, frame_accept_out, rs485_out;
    logic rts_en_out, pin_lock_out, sleep_request_in;
    logic [1:0] rf_level_out, retries_out;
    logic [2:0] band_out;
    logic [3:0] nv_addr_out;
    logic [7:0] rx_char_in;
    logic [15:0] nv_wdata_out, nv_rdata_in, rx_adr_in, tx_tag_out, pin_code_out, lfsr, v;
    logic [15:0] xp [16];
    msc_cmd_t cmd_in;
    msc_rsp_t rsp_out;
    msc_fmt_t fmt_out;
    int bad_count = 0, checked = 0, cyc = 0, n;
    localparam logic [8:0] OFS [16] = '{9'h0cd, 9'h0cf, 9'h0d2, 9'h0d3, 9'h0d4, 9'h0d5,
        9'h0d6, 9'h0d7, 9'h0d8, 9'h0db, 9'h0dc, 9'h0dd, 9'h0e7, 9'h0e8, 9'h0fc, 9'h100};
    localparam logic [15:0] DFLT [16] = '{16'h1111, 16'h0, 16'h4, 16'h8, 16'h1, 16'h1,
        16'h8, 16'h1, 16'h2, 16'h3, 16'h2, 16'h0, 16'h3, 16'h0, 16'h0, 16'h0};
    // Boundary writes: register index, value
    localparam logic [23:0] COR [18] = '{24'h000000, 24'h010002, 24'h020000, 24'h020008,
        24'h030006, 24'h040004, 24'h050003, 24'h060000, 24'h060065, 24'h060064, 24'h0900a1,
        24'h0900a0, 24'h0a0005, 24'h0c0004, 24'h070100, 24'h080001, 24'h080000, 24'h0b0002};
    msc_config_bank #(.GUARD_UNIT_CYC(20)) msc_config_bank_inst (.*);
    msc_nv_model msc_nv_model_inst (.clk_in(clk_in), .addr_in(nv_addr_out), .we_in(nv_we_out),
        .wdata_in(nv_wdata_out), .rdata_out(nv_rdata_in));
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction : rnd
    function automatic logic legal(input int i, input logic [15:0] d);
        case (i)
            0: return d != 16'h0;
            2: return d inside {[1:7]};
            3: return d inside {7, 8};
            4: return d inside {[1:3]};
            5: return d inside {1, 2};
            6: return d inside {[1:100]};
            8: return d inside {0, 2};
            9: return d <= 160;
            10: return d inside {[2:4]};
            11, 12: return d <= 2 + (i == 12);
            14, 15: return 1'b1;
            default: return d < 2;
        endcase
    endfunction : legal
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        checked++;
        if (got !== want) begin
            bad_count++;
            $display("BAD %0t %h %h", $time, got, want);
        end
    endtask : chk
    task automatic tick(input int k);
        repeat (k) @(negedge clk_in);
    endtask : tick
    task automatic cmd(input msc_op_t op, input logic [8:0] num, input logic [15:0] d);
        for (n = 0; cmd_ready_out !== 1'b1 && n < 100; n++) tick(1);
        cmd_in = '{op, num, d};
        cmd_valid_in = 1'b1;
        tick(1);
        cmd_valid_in = 1'b0;
        for (n = 0; rsp_valid_out !== 1'b1 && n < 40; n++) tick(1);
        chk({rsp_valid_out, rsp_out.num}, {1'b1, num});
    endtask : cmd
    task automatic setq(input int i, input logic [15:0] d);
        logic ok;
        ok = legal(i, d);
        cmd(MSC_OP_SET, OFS[i], d);
        chk(rsp_out.ok, ok);
        if (ok && i == 2 && d < 3 && xp[6] < 4 - d) xp[6] = 4 - d;
        if (ok) xp[i] = d;
        cmd(MSC_OP_QUERY, OFS[i], 16'h0);
        chk(rsp_out.value, xp[i]);
    endtask : setq
    task automatic qall();
        for (int i = 0; i < 16; i++) begin
            cmd(MSC_OP_QUERY, OFS[i], 16'h0);
            chk(rsp_out.value, xp[i]);
        end
    endtask : qall
    task automatic outs();
        logic r;
        r = xp[7][0] & !iface_strap_in;
        chk({rf_level_out, band_out, retries_out}, {xp[12][1:0], xp[10][2:0], xp[11][1:0]});
        chk(fmt_out, {xp[2][2:0], xp[3] == 16'h8, xp[4][1:0], xp[5] == 16'h2});
        chk({rs485_out, rts_en_out}, {r, xp[8] == 16'h0});
        chk({pin_lock_out, pin_code_out, tx_tag_out}, {xp[1][0], xp[0], xp[15]});
        chk(sleep_out, xp[13][0] & sleep_request_in);
        addressed_mode_in = lfsr[5];
        rx_adr_in = lfsr[6] ? xp[14] : rnd();
        rx_adr_valid_in = 1'b1;
        tick(1);
        rx_adr_valid_in = 1'b0;
        chk(frame_accept_out, !addressed_mode_in || rx_adr_in == xp[14]);
        tx_req_in = 1'b1;
        for (n = 0; tx_go_out !== 1'b1 && n < 7000; n++) tick(1);
        chk(driver_en_out, r);
        chk(n >= xp[9] * 40 * r && n <= xp[9] * 40 * r + 4, 1);
        tx_req_in = 1'b0;
        tick(1);
    endtask : outs
    task automatic esc(input logic [7:0] last, input logic want);
        tick(xp[6] * 20 + 4);
        for (int k = 0; k < 3; k++) begin
            rx_char_in = k == 2 ? last : 8'h2b;
            rx_char_valid_in = 1'b1;
            tick(1);
            rx_char_valid_in = 1'b0;
            tick(1);
        end
        tick(xp[6] * 20 - 4);
        chk(cmd_mode_out, 1'b0);
        tick(8);
        chk(cmd_mode_out, want);
        cmd_exit_in = 1'b1;
        tick(1);
        cmd_exit_in = 1'b0;
    endtask : esc
    task automatic tally_and_finish();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    initial begin
        {cmd_valid_in, rx_char_valid_in, cmd_exit_in, iface_strap_in, tx_req_in} = '0;
        {addressed_mode_in, rx_adr_valid_in, sleep_request_in, rx_char_in, rx_adr_in} = '0;
        cmd_in = '0;
        lfsr = 16'h0051;
        xp = DFLT;
        reset_in = 1'b1;
        tick(5);
        chk(pin_code_out, DFLT[0]);
        reset_in = 1'b0;
        // Erased storage: illegal entries fall back to defaults
        {xp[0], xp[14], xp[15]} = {3{16'hffff}};
        qall();
        for (int k = 0; k < 18; k++) setq(COR[k][23:16], COR[k][15:0]);
        cmd(MSC_OP_SET, 9'h101, 16'h0);
        chk(rsp_out.ok, 1'b0);
        $display("end corners");
        repeat (6) begin
            sleep_request_in = lfsr[3];
            for (int i = 0; i < 16; i++) begin
                v = rnd();
                v = (i == 0 || i > 13) ? v : (v[15] ? v & 16'h01ff : v % 9);
                if (i == 8 && (xp[11] != 16'h0 || xp[2] >= 16'h4)) v[1] = 1'b0;
                if (i == 11) v = xp[8] == 16'h0 ? v % 3 : 16'h0;
                setq(i, v);
            end
            outs();
        end
        $display("end random");
        cmd(MSC_OP_SAVE, 9'h0, 16'h0);
        chk(rsp_out.ok, 1'b1);
        // Strap high from here on: RS232 even with line type 1
        iface_strap_in = 1'b1;
        reset_in = 1'b1;
        tick(5);
        reset_in = 1'b0;
        qall();
        cmd(MSC_OP_RESTORE, 9'h0, 16'h0);
        xp = DFLT;
        qall();
        outs();
        $display("end save");
        setq(6, 16'h3);
        esc(8'h2b, 1'b1);
        esc(8'h41, 1'b0);
        $display("end escape");
        tally_and_finish();
    end
endmodule : testbench
